// [csm_map.svh]
// Purpose: offsets, field positions, reset values and timing counts of the charge session block
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes:   times are kept in their own unit; cycle counts derive from them
//
// Functional notes
// - session progress is signalled to the vehicle by pwm on the pilot line
// - charging never starts unless cable capacity sense reports an adequate cable or the fixed-cable setting is on
// - a fixed-cable setting bypasses the cable capacity check
// - immediate mode: start key begins charging at once, full power all session
// - mode lamp is dark while immediate mode is selected
// - minimum-cost mode charges only in low-rate periods, pauses in high-rate
// - time key or command changes mode; minimum-cost blinks mode lamp slowly
// - mode lamp is steady on while scheduled mode is selected
// - scheduled mode charges low-rate, and high-rate when departure time demands
// - timed modes need valid system time; scheduled also needs rate periods
// - meter pulses convert to energy, scale default 1600 per kWh, configurable
// - with a card reader, start and time keys are blocked until a card opens a window; stop key is not
// - extra system states are shown by combinations of the three lamps
// - start, time and stop keys are asserted when low
// - stop key ends the session and locks the outlet
// - contactor feedback low means a fault
`ifndef CSM_MAP_SVH
`define CSM_MAP_SVH

`define CSM_CLK_KHZ        100000
`define CSM_PWM_FREQ_HZ    1000
`define CSM_DEB_MS         10
`define CSM_BLINK_HALF_MS  500
`define CSM_AUTH_MS        60000

`define CSM_REG_CTRL       8'h00
`define CSM_REG_CMD        8'h04
`define CSM_REG_SCALE      8'h08
`define CSM_REG_DUTY       8'h0C
`define CSM_REG_STATUS     8'h10
`define CSM_REG_ENERGY     8'h14

`define CSM_CTRL_FIXED     0
`define CSM_CTRL_READER    1
`define CSM_CTRL_TIME_OK   2
`define CSM_CTRL_RATES_OK  3
`define CSM_CTRL_LOW_RATE  4
`define CSM_CTRL_NEED_HIGH 5
`define CSM_CTRL_W         6

`define CSM_CMD_MODE_LO    0
`define CSM_CMD_MODE_WR    2
`define CSM_CMD_CARD       3

`define CSM_CTRL_RST       6'h00
`define CSM_SCALE_RST      16'h0640
`define CSM_DUTY_RST       10'h216

`endif

// [csm_pkg.sv]
// Purpose: types of the charge session block
// Assumes: nothing
// Notes:   constants live in csm_map.svh
package csm_pkg;
   typedef enum logic [1:0]
   {
      csm_imm = 2'b00,
      csm_min = 2'b01,
      csm_sch = 2'b10
   } csm_mode_e;

   typedef enum logic
   {
      csm_idle    = 1'b0,
      csm_session = 1'b1
   } csm_state_e;
endpackage : csm_pkg

// [csm_key_if.sv]
// Purpose: key press pulses and timebase between key filter and controller
// Assumes: single hclk domain
// Notes:   press bits: 0 start, 1 time, 2 stop
`timescale 1ns/1ns
interface csm_key_if;
   logic       tick;
   logic [2:0] press;
   modport keys (input tick, output press);
   modport ctl  (output tick, input press);
endinterface : csm_key_if

// [csm_keys.sv]
// Purpose: synchronise and debounce active-low keys, one pulse per press
// Assumes: tick is a one-cycle millisecond enable
// Notes:   debounced level must be stable for DEB_TICKS ticks
`timescale 1ns/1ns
`include "csm_map.svh"
module csm_keys #(
   parameter int N         = 3,
   parameter int DEB_TICKS = `CSM_DEB_MS
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [N-1:0] raw_n,
   csm_key_if.keys           kif
);
   genvar g;
   for (g = 0; g < N; g++)
   begin : g_key
      logic [1:0] sync;
      logic       level;
      logic [7:0] cnt;
      logic       press;

      // -----------------------------------------
      // synchroniser, asserted high after inversion
      // -----------------------------------------
      // keys active low
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            sync <= 2'h0;
         else
            sync <= {sync[0], ~raw_n[g]};
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            cnt   <= 8'h00;
            level <= 1'b0;
         end
         else if (sync[1] == level)
            cnt <= 8'h00;
         else if (kif.tick)
         begin
            if (cnt == 8'(DEB_TICKS - 1))
            begin
               level <= sync[1];
               cnt   <= 8'h00;
            end
            else
               cnt <= cnt + 8'h01;
         end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            press <= 1'b0;
         else
            press <= kif.tick && sync[1] && !level && (cnt == 8'(DEB_TICKS - 1));
      end
      assign kif.press[g] = press;

      a_press_single : assert property (@(posedge hclk) disable iff (!hresetn)
         press |=> !press)
         else $error("key press pulse longer than one cycle");
   end
endmodule : csm_keys

// [csm_top.sv]
// Purpose: charge session and mode control with AHB-Lite registers
// Assumes: 100 MHz hclk; pins are asynchronous to hclk
// Notes:   all outputs are flip-flops
`timescale 1ns/1ns
`include "csm_map.svh"
module csm_top #(
   parameter int PWM_CYCLES = (`CSM_CLK_KHZ * 1000) / `CSM_PWM_FREQ_HZ,
   parameter int DEB_TICKS  = `CSM_DEB_MS,
   parameter int BLINK_HALF = `CSM_BLINK_HALF_MS,
   parameter int AUTH_TICKS = `CSM_AUTH_MS
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        start_key_n,
   input  wire logic        time_key_n,
   input  wire logic        stop_key_n,
   input  wire logic        cable_capacity_sense,
   input  wire logic        vehicle_present,
   input  wire logic        contactor_feedback_n,
   input  wire logic        meter_pulse,
   output logic             vehicle_pilot_line,
   output logic             contactor_drive,
   output logic             outlet_lock,
   output logic             session_state_lamp,
   output logic             mode_lamp,
   output logic             fault_lamp
);
   import csm_pkg::*;

   csm_key_if kif ();
   csm_mode_e  mode;
   csm_state_e state;
   logic [`CSM_CTRL_W-1:0] ctrl;
   logic [15:0] scale;
   logic [9:0]  duty;
   logic [16:0] pwm_cnt;
   logic        ms_tick;
   logic [8:0]  blink_cnt;
   logic        blink;
   logic [15:0] auth_cnt;
   logic        auth_active;
   logic [1:0]  cab_s, veh_s, flt_s, mtr_s;
   logic        mtr_d;
   logic [15:0] pulse_cnt;
   logic [15:0] kwh;
   logic        refused;
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic        power_ok;
   logic        fault;
   logic        cable_ok;
   logic        keys_ok;
   logic        start_ok;
   logic [26:0] duty_cycles;
   logic        cmd_wr;
   logic        timed_ok;

   assign kif.tick = ms_tick;

   csm_keys #(.N(3), .DEB_TICKS(DEB_TICKS)) u_keys (
      .hclk    (hclk),
      .hresetn (hresetn),
      .raw_n   ({stop_key_n, time_key_n, start_key_n}),
      .kif     (kif)
   );

   // -----------------------------------------
   // pin synchronisers
   // -----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cab_s <= 2'h0;
         veh_s <= 2'h0;
         flt_s <= 2'h0;
         mtr_s <= 2'h0;
      end
      else
      begin
         cab_s <= {cab_s[0], cable_capacity_sense};
         veh_s <= {veh_s[0], vehicle_present};
         flt_s <= {flt_s[0], ~contactor_feedback_n};
         mtr_s <= {mtr_s[0], meter_pulse};
      end
   end

   assign fault    = flt_s[1];
   assign cable_ok = cab_s[1] || ctrl[`CSM_CTRL_FIXED];
   assign keys_ok  = !ctrl[`CSM_CTRL_READER] || auth_active;
   assign start_ok = kif.press[0] && keys_ok && cable_ok && !fault && state == csm_idle;
   assign timed_ok = ctrl[`CSM_CTRL_TIME_OK];

   // -----------------------------------------
   // power permission per mode
   // -----------------------------------------
   always_comb
   begin
      unique case (mode)
         csm_imm: power_ok = 1'b1;
         csm_min: power_ok = ctrl[`CSM_CTRL_LOW_RATE];
         csm_sch: power_ok = ctrl[`CSM_CTRL_LOW_RATE] || ctrl[`CSM_CTRL_NEED_HIGH];
         default: power_ok = 1'b0;
      endcase
   end

   // -----------------------------------------
   // pwm timebase, millisecond tick, blink
   // -----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pwm_cnt <= 17'h00000;
         ms_tick <= 1'b0;
      end
      else
      begin
         ms_tick <= (pwm_cnt == 17'(PWM_CYCLES - 1));
         if (pwm_cnt == 17'(PWM_CYCLES - 1))
            pwm_cnt <= 17'h00000;
         else
            pwm_cnt <= pwm_cnt + 17'h00001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         blink_cnt <= 9'h000;
         blink     <= 1'b0;
      end
      else if (ms_tick)
      begin
         if (blink_cnt == 9'(BLINK_HALF - 1))
         begin
            blink_cnt <= 9'h000;
            blink     <= !blink;
         end
         else
            blink_cnt <= blink_cnt + 9'h001;
      end
   end

   // -----------------------------------------
   // session state, outlet lock, refusal flag
   // -----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state       <= csm_idle;
         outlet_lock <= 1'b0;
         refused     <= 1'b0;
      end
      else
      begin
         if (kif.press[2] || fault || !veh_s[1])
         begin
            state       <= csm_idle;
            outlet_lock <= outlet_lock || kif.press[2];
         end
         else if (start_ok)
         begin
            state       <= csm_session;
            outlet_lock <= 1'b0;
            refused     <= 1'b0;
         end
         else if (kif.press[0] && keys_ok && !cable_ok)
            refused <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         auth_cnt    <= 16'h0000;
         auth_active <= 1'b0;
      end
      else if (cmd_wr && hwdata[`CSM_CMD_CARD])
      begin
         auth_cnt    <= 16'(AUTH_TICKS - 1);
         auth_active <= 1'b1;
      end
      else if (ms_tick && auth_active)
      begin
         if (auth_cnt == 16'h0000)
            auth_active <= 1'b0;
         else
            auth_cnt <= auth_cnt - 16'h0001;
      end
   end

   // -----------------------------------------
   // mode selection
   // -----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode <= csm_imm;
      else if (!timed_ok)
         mode <= csm_imm;
      else if (cmd_wr && hwdata[`CSM_CMD_MODE_WR])
      begin
         if (hwdata[1:0] == csm_min)
            mode <= csm_min;
         else if (hwdata[1:0] == csm_sch && ctrl[`CSM_CTRL_RATES_OK])
            mode <= csm_sch;
         else if (hwdata[1:0] == csm_imm)
            mode <= csm_imm;
      end
      else if (kif.press[1] && keys_ok)
         mode <= (mode == csm_imm) ? csm_min : csm_imm;
   end

   // -----------------------------------------
   // pilot pwm and contactor
   // -----------------------------------------
   assign duty_cycles = 27'(duty * 17'(PWM_CYCLES / 1000));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         vehicle_pilot_line <= 1'b1;
         contactor_drive    <= 1'b0;
      end
      else
      begin
         vehicle_pilot_line <= (state == csm_idle) || (27'(pwm_cnt) < duty_cycles);
         contactor_drive    <= (state == csm_session) && power_ok && !fault;
      end
   end

   // -----------------------------------------
   // lamps
   // -----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         session_state_lamp <= 1'b0;
         mode_lamp          <= 1'b0;
         fault_lamp         <= 1'b0;
      end
      else
      begin
         // refusal: session and fault lamps blink together
         if (refused && !fault)
         begin
            session_state_lamp <= blink;
            fault_lamp         <= blink;
         end
         else
         begin
            session_state_lamp <= contactor_drive || (veh_s[1] && blink);
            fault_lamp         <= fault;
         end
         mode_lamp <= (mode == csm_sch) || (mode == csm_min && blink);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mtr_d     <= 1'b0;
         pulse_cnt <= 16'h0000;
         kwh       <= 16'h0000;
      end
      else
      begin
         mtr_d <= mtr_s[1];
         if (mtr_s[1] && !mtr_d)
         begin
            if (pulse_cnt + 16'h0001 >= scale)
            begin
               pulse_cnt <= 16'h0000;
               kwh       <= kwh + 16'h0001;
            end
            else
               pulse_cnt <= pulse_cnt + 16'h0001;
         end
      end
   end

   // -----------------------------------------
   // ahb-lite slave, zero wait
   // -----------------------------------------
   assign cmd_wr = wr_pend && wr_addr == `CSM_REG_CMD;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend   <= 1'b0;
         wr_addr   <= 8'h00;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else if (hready)
      begin
         wr_pend <= hsel && htrans[1] && hwrite;
         wr_addr <= haddr[7:0];
         hrdata  <= 32'h00000000;
         if (hsel && htrans[1] && !hwrite)
         begin
            unique case (haddr[7:0])
               `CSM_REG_CTRL:   hrdata <= 32'(ctrl);
               `CSM_REG_SCALE:  hrdata <= 32'(scale);
               `CSM_REG_DUTY:   hrdata <= 32'(duty);
               `CSM_REG_STATUS: hrdata <= {21'h000000, auth_active, outlet_lock, refused,
                                   fault, cable_ok, veh_s[1], contactor_drive,
                                   state, mode, 1'b0};
               `CSM_REG_ENERGY: hrdata <= {kwh, pulse_cnt};
               default:         hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl  <= `CSM_CTRL_RST;
         scale <= `CSM_SCALE_RST;
         duty  <= `CSM_DUTY_RST;
      end
      else if (wr_pend)
      begin
         unique case (wr_addr)
            `CSM_REG_CTRL:  ctrl <= hwdata[`CSM_CTRL_W-1:0];
            `CSM_REG_SCALE: scale <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
            `CSM_REG_DUTY:  duty <= hwdata[9:0];
            default:        ctrl <= ctrl;
         endcase
      end
   end

   // -----------------------------------------
   // assertions
   // -----------------------------------------
   a_start_cable : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state) |-> $past(cable_ok)) else $error("session started without cable");
   a_start_card : assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state) |-> $past(keys_ok)) else $error("session started without card");
   a_imm_power : assert property (@(posedge hclk) disable iff (!hresetn)
      state == csm_session && mode == csm_imm && !fault ##1 state == csm_session
      |-> contactor_drive) else $error("immediate session not at full power");
   a_min_pause : assert property (@(posedge hclk) disable iff (!hresetn)
      mode == csm_min && !ctrl[`CSM_CTRL_LOW_RATE] |=> !contactor_drive)
      else $error("charging during high rate");
   a_lamp_imm : assert property (@(posedge hclk) disable iff (!hresetn)
      mode == csm_imm |=> !mode_lamp) else $error("mode lamp lit in immediate");
   a_lamp_sched : assert property (@(posedge hclk) disable iff (!hresetn)
      mode == csm_sch |=> mode_lamp) else $error("mode lamp dark in scheduled");
   a_fault_lamp : assert property (@(posedge hclk) disable iff (!hresetn)
      fault && !refused |=> fault_lamp) else $error("fault lamp dark during fault");
   a_stop_lock : assert property (@(posedge hclk) disable iff (!hresetn)
      kif.press[2] |=> state == csm_idle && outlet_lock ##1 !contactor_drive)
      else $error("stop did not end session");
   a_mode_time : assert property (@(posedge hclk) disable iff (!hresetn)
      mode != csm_imm |-> $past(timed_ok)) else $error("timed mode without time");
   a_pilot_idle : assert property (@(posedge hclk) disable iff (!hresetn)
      state == csm_idle [*2] |-> vehicle_pilot_line) else $error("pilot pwm while idle");

   c_session : cover property (@(posedge hclk) disable iff (!hresetn) $rose(state));
   c_pause : cover property (@(posedge hclk) disable iff (!hresetn)
      state == csm_session && mode == csm_min && !contactor_drive);
   c_card : cover property (@(posedge hclk) disable iff (!hresetn) $rose(auth_active));
endmodule : csm_top

// [csm_ev_model.sv]
// Purpose: vehicle and energy meter facing the charge session block
// Assumes: changes land just after rising hclk
// Notes:   cable and fault levels follow the bench's scenario controls
`timescale 1ns/1ns
module csm_ev_model (
   input  wire logic hclk,
   input  wire logic cable_ok,
   input  wire logic fault,
   output logic      vehicle_present,
   output logic      cable_capacity_sense,
   output logic      contactor_feedback_n,
   output logic      meter_pulse
);
   initial
   begin
      vehicle_present      = 1'b0;
      cable_capacity_sense = 1'b0;
      contactor_feedback_n = 1'b1;
      meter_pulse          = 1'b0;
   end

   // vehicle plugged in after the first edge
   always @(posedge hclk)
   begin
      vehicle_present      <= 1'b1;
      cable_capacity_sense <= cable_ok;
      contactor_feedback_n <= ~fault;
   end

   // meter pulses, wide enough to pass the input synchroniser
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge hclk);
         meter_pulse <= 1'b1;
         repeat (4) @(posedge hclk);
         meter_pulse <= 1'b0;
         repeat (4) @(posedge hclk);
      end
   endtask : pulses
endmodule : csm_ev_model

// [tb.sv]
// Purpose: self-checking bench of the charge session block
// Assumes: small counts, pilot period of 1000 cycles
// Notes:   random values from a fixed seed
`timescale 1ns/1ns
`include "csm_map.svh"
module tb;
   import csm_pkg::*;
   localparam int PWM   = 1000;
   localparam int DEB   = 2;
   localparam int PRESS = (DEB + 1) * PWM + 50;
   localparam int BLINK = 4 * PWM + 100;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, e0;
   logic [1:0]  htrans;
   logic [2:0]  hsize, key_n;
   logic        vp, cap, fb_n, pulse, pilot, cont, lock, s_lamp, m_lamp, f_lamp;
   logic        cable_ok, fault, hit;
   int          err_total, cmp_count, cyc, seed, s, n;

   assign hready = hreadyout;
   csm_top #(.PWM_CYCLES(PWM), .DEB_TICKS(DEB), .BLINK_HALF(2), .AUTH_TICKS(5)) u_csm_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .start_key_n(key_n[0]),
      .time_key_n(key_n[1]), .stop_key_n(key_n[2]), .cable_capacity_sense(cap),
      .vehicle_present(vp), .contactor_feedback_n(fb_n), .meter_pulse(pulse),
      .vehicle_pilot_line(pilot), .contactor_drive(cont), .outlet_lock(lock),
      .session_state_lamp(s_lamp), .mode_lamp(m_lamp), .fault_lamp(f_lamp));
   csm_ev_model u_csm_ev_model (
      .hclk(hclk), .cable_ok(cable_ok), .fault(fault), .vehicle_present(vp),
      .cable_capacity_sense(cap), .contactor_feedback_n(fb_n), .meter_pulse(pulse));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : ahb

   task automatic press(input int k);
      @(posedge hclk);
      key_n[k] <= 1'b0;
      repeat (PRESS) @(posedge hclk);
      key_n[k] <= 1'b1;
      repeat (PRESS) @(posedge hclk);
   endtask : press

   function automatic logic pick(input int i);
      case (i)
         0: return pilot;
         1: return m_lamp;
         default: return f_lamp;
      endcase
   endfunction : pick

   task automatic seen(input int i, input logic v, input int lim);
      hit = 1'b0;
      // let a lamp launched by the last write settle before sampling
      repeat (2) @(posedge hclk);
      repeat (lim)
      begin
         @(posedge hclk);
         if (pick(i) === v)
            hit = 1'b1;
      end
   endtask : seen

   function automatic logic [31:0] energy_exp(input logic [31:0] e, input int sc, input int np);
      int tot;
      tot = e[31:16] * sc + e[15:0] + np;
      return {16'(tot / sc), 16'(tot % sc)};
   endfunction : energy_exp

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask : done

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 95000)
      begin
         err_total++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize     = 3'b010;
      key_n     = 3'b111;
      cable_ok  = 1'b0;
      fault     = 1'b0;
      err_total = 0;
      cmp_count = 0;
      cyc       = 0;
      seed      = 32'h2E32;
      hresetn   = 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(0, `CSM_REG_SCALE, 0);
      chk("scale", rd, 32'h640);
      chk("hresp", hresp, 0);
      ahb(0, 8'h20, 0);
      chk("unmapped", rd, 32'h0);
      chk("pilot idle", pilot, 1);
      chk("fault lamp", f_lamp, 0);
      done("reset");
      press(0);
      chk("refused", cont, 0);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("refused bit", rd[8], 1);
      seen(2, 1, BLINK);
      chk("refused lamps", hit, 1);
      ahb(1, `CSM_REG_CTRL, 32'h1);
      press(0);
      chk("contactor", cont, 1);
      chk("charge lamp", s_lamp, 1);
      chk("mode lamp", m_lamp, 0);
      seen(0, 0, PWM + 10);
      chk("pilot pwm", hit, 1);
      press(2);
      chk("stopped", cont, 0);
      chk("lock", lock, 1);
      done("start stop");
      ahb(1, `CSM_REG_CMD, 32'h5);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("no time", rd[2:1], 0);
      ahb(1, `CSM_REG_CTRL, 32'h5);
      ahb(1, `CSM_REG_CMD, 32'h5);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("mode min", rd[2:1], 1);
      seen(1, 1, BLINK);
      chk("blink on", hit, 1);
      seen(1, 0, BLINK);
      chk("blink off", hit, 1);
      ahb(1, `CSM_REG_CMD, 32'h6);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("no rates", rd[2:1], 1);
      ahb(1, `CSM_REG_CTRL, 32'hD);
      ahb(1, `CSM_REG_CMD, 32'h6);
      seen(1, 0, BLINK);
      chk("sched lamp", hit, 0);
      ahb(1, `CSM_REG_CMD, 32'h4);
      press(1);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("time key", rd[2:1], 1);
      done("modes");
      press(0);
      ahb(0, `CSM_REG_STATUS, 0);
      chk("session", rd[3], 1);
      chk("high rate", cont, 0);
      ahb(1, `CSM_REG_CTRL, 32'h1D);
      repeat (3) @(posedge hclk);
      chk("low rate", cont, 1);
      s = 2 + ($random(seed) & 3);
      n = 1 + ($random(seed) & 15);
      ahb(1, `CSM_REG_SCALE, s);
      ahb(0, `CSM_REG_ENERGY, 0);
      e0 = rd;
      u_csm_ev_model.pulses(n);
      ahb(0, `CSM_REG_ENERGY, 0);
      chk("energy", rd, energy_exp(e0, s, n));
      ahb(1, `CSM_REG_SCALE, 0);
      ahb(0, `CSM_REG_SCALE, 0);
      chk("scale zero", rd, 32'h1);
      n = $random(seed) & 32'h3FF;
      ahb(1, `CSM_REG_DUTY, n);
      ahb(0, `CSM_REG_DUTY, 0);
      chk("duty", rd, n);
      ahb(1, `CSM_REG_CMD, 32'h6);
      ahb(1, `CSM_REG_CTRL, 32'h2D);
      repeat (3) @(posedge hclk);
      chk("need high", cont, 1);
      ahb(1, `CSM_REG_CTRL, 32'h0D);
      repeat (3) @(posedge hclk);
      chk("sched wait", cont, 0);
      press(2);
      done("rates meter");
      ahb(1, `CSM_REG_CMD, 32'h4);
      ahb(1, `CSM_REG_CTRL, 32'h3);
      press(0);
      chk("no card", cont, 0);
      ahb(1, `CSM_REG_CMD, 32'h8);
      press(0);
      chk("card start", cont, 1);
      fault <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("fault lamp on", f_lamp, 1);
      chk("fault stop", cont, 0);
      fault <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("fault lamp off", f_lamp, 0);
      done("card fault");
      print_verdict();
   end
endmodule : tb
